// file: sbc_host_model.sv
/* host side of the spi link.
   assumes the bench calls its tasks; link clock stands still between frames. */
`timescale 1ns/10ps
`default_nettype none
module sbc_host_model (
  // link toward the sequencer
  output logic spi_clk_out,
  output logic spi_csn_out,
  output logic frame_done_out,
  output sbc_mode_pkg::mode_cmd_t cmd_out,
  output logic wd_config_out
);
  import sbc_mode_pkg::*;
  // ====
  // idle link
  initial begin
    spi_clk_out = 1'b0;
    spi_csn_out = 1'b1;
    frame_done_out = 1'b0;
    cmd_out = CMD_NONE;
    wd_config_out = 1'b0;
  end
  // one 15 ns link clock
  task automatic tick();
    #7.5 spi_clk_out = 1'b1;
    #7.5 spi_clk_out = 1'b0;
  endtask : tick
  // frame ending with select rise after hold ticks
  task automatic frame(input mode_cmd_t c, input logic w, input int hold);
    #2 spi_csn_out = 1'b0; // link phase kept off the system clock edge
    repeat (8) tick();
    cmd_out = c;
    wd_config_out = w;
    frame_done_out = 1'b1;
    tick();
    frame_done_out = 1'b0;
    cmd_out = mode_cmd_t'(~c); // released lines show junk
    wd_config_out = ~w;
    repeat (hold) tick();
    spi_csn_out = 1'b1;
  endtask : frame
  // bare select pulse wakes from stop
  task automatic wake();
    #2 spi_csn_out = 1'b0;
    #41 spi_csn_out = 1'b1;
  endtask : wake
endmodule : sbc_host_model
`default_nettype wire

// file: sbc_mode_chk.sv
/* port checks for the mode sequencer.
   assumes a bind into the sequencer and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module sbc_mode_chk #(
  parameter int unsigned NR_TIMEOUT_CYCLES = 2000
) (
  // watched ports
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic spi_csn_in,
  input wire logic spi_accept_out,
  input wire logic main_reg_on_out,
  input wire logic aux_regulator_on_out,
  input wire logic can_tx_en_out,
  input wire logic rstn_out,
  input wire logic intn_out,
  input wire sbc_mode_pkg::mode_t mode_out,
  input wire logic interrupt_flag_reg_out
);
  import sbc_mode_pkg::*;
  logic [11:0] low_q;
  logic [31:0] nr_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ====
  // count interrupt low cycles and normal request dwell
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_q <= 12'h000;
      nr_q <= 32'h0;
    end else begin
      low_q <= intn_out ? 12'h000 : low_q + 12'h001;
      nr_q <= (mode_out == MODE_NORM_REQ) ? nr_q + 32'h1 : 32'h0;
    end
  end
  a_nr_supply: assert property (
    nr_q >= 32'h2 && mode_out == MODE_NORM_REQ |-> main_reg_on_out && !aux_regulator_on_out
    && rstn_out) else $error("request supplies wrong");
  a_int_nr: assert property ($fell(intn_out) |-> mode_out == MODE_NORM_REQ)
    else $error("interrupt outside request");
  a_int_width: assert property ($rose(intn_out) |-> low_q == 12'h4e2)
    else $error("interrupt width wrong");
  a_csn_wake: assert property (
    mode_out == MODE_STOP && $rose(spi_csn_in) |-> ##[1:6] mode_out == MODE_NORM_REQ)
    else $error("select rise did not wake");
  a_no_iflag: assert property (interrupt_flag_reg_out == 1'b0)
    else $error("interrupt flag set");
  a_nr_limit: assert property (nr_q <= NR_TIMEOUT_CYCLES + 32'h8)
    else $error("request outlived timeout");
  a_rst_low: assert property (
    $past(mode_out) == MODE_RESET && $past(mode_out, 2) == MODE_RESET |-> !rstn_out)
    else $error("reset output high in reset");
  a_quiet_int: assert property (!intn_out |-> !spi_accept_out)
    else $error("accepting during pulse");
  a_quiet_after: assert property ($rose(intn_out) |-> !spi_accept_out [*8])
    else $error("accepting right after pulse");
  a_standby_off: assert property (
    $past(mode_out) == MODE_STANDBY && $past(mode_out, 2) == MODE_STANDBY
    |-> !aux_regulator_on_out && !can_tx_en_out) else $error("standby drives on");
  c_int: cover property ($rose(intn_out));
  c_stop: cover property (mode_out == MODE_STOP);
  c_sleep: cover property (mode_out == MODE_SLEEP);
endmodule : sbc_mode_chk
bind sbc_mode_wake_sequencer sbc_mode_chk #(.NR_TIMEOUT_CYCLES(NR_TIMEOUT_CYCLES)) u_sbc_mode_chk (
  .clock_in, .rstn_in, .spi_csn_in, .spi_accept_out, .main_reg_on_out,
  .aux_regulator_on_out, .can_tx_en_out, .rstn_out, .intn_out, .mode_out,
  .interrupt_flag_reg_out);
`default_nettype wire

// file: sbc_mode_consts.svh
/*
  timing counts and the wake line count for the mode/wake sequencer.
  assumes a 125 mhz system clock; counts derive from times below.
*/
`ifndef SBC_MODE_CONSTS_SVH
`define SBC_MODE_CONSTS_SVH

// ==========================================================
// clock
`define CLK_MHZ 125

// ==========================================================
// times in their own units
`define NR_TIMEOUT_MS 350
`define INT_PULSE_US 10
`define STOP_DEGLITCH_US 40
`define FIRST_SPI_DELAY_US 20
`define RESET_PULSE_US 15000

// ==========================================================
// derived cycle counts (exact products of time and clock rate, no rounding)
`define INT_PULSE_CYC (`INT_PULSE_US * `CLK_MHZ)
`define STOP_DEGLITCH_CYC (`STOP_DEGLITCH_US * `CLK_MHZ)
`define FIRST_SPI_DELAY_CYC (`FIRST_SPI_DELAY_US * `CLK_MHZ)
`define NR_TIMEOUT_CYC (`NR_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define RESET_PULSE_CYC (`RESET_PULSE_US * `CLK_MHZ)

// ==========================================================
// number of local wake lines
`define WAKE_LINES 4

`endif

// file: sbc_mode_pkg.sv
/*
  types for the mode/wake sequencer.
  assumes nothing beyond a systemverilog compiler.
*/
package sbc_mode_pkg;
  // operating modes of the device
  typedef enum logic [3:0] {
    MODE_RESET,
    MODE_NORM_REQ,
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_STOP,
    MODE_SLEEP
  } mode_t;

  // commands delivered by the spi frame decoder
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_NORMAL,
    CMD_STANDBY,
    CMD_STOP,
    CMD_SLEEP
  } mode_cmd_t;

  // reason normal request was entered
  typedef enum logic [1:0] {
    ORIGIN_RESET,
    ORIGIN_STOP,
    ORIGIN_SLEEP
  } origin_t;
endpackage : sbc_mode_pkg

// file: sbc_mode_wake_sequencer.sv
/*
  operating-mode and wake sequencer of a system basis chip.
  assumes the spi frame decoder runs in the link clock domain (spi_clk_in) and
  presents a decoded mode command with a frame-done strobe near frame end;
  stop and sleep then wait for the chip-select rise that closes the frame;
  analog detectors arrive asynchronously and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sbc_mode_consts.svh"

module sbc_mode_wake_sequencer #(
  parameter int unsigned NR_TIMEOUT_CYCLES = `NR_TIMEOUT_CYC,
  parameter int unsigned RESET_PULSE_CYCLES = `RESET_PULSE_CYC,
  parameter int unsigned FIRST_SPI_DELAY_CYCLES = `FIRST_SPI_DELAY_CYC
) (
  // system clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // spi link domain: decoded frame from the link logic
  input wire logic spi_clk_in,
  input wire logic spi_csn_in,
  input wire logic spi_frame_done_in,
  input wire sbc_mode_pkg::mode_cmd_t spi_cmd_in,
  input wire logic spi_wd_config_in,
  output logic spi_accept_out,
  // asynchronous detectors
  input wire logic vdd_low_in,
  input wire logic wd_timeout_in,
  input wire logic wd_closed_trig_in,
  input wire logic can_wake_in,
  input wire logic [`WAKE_LINES-1:0] wake_line_in,
  input wire logic forced_wake_in,
  input wire logic stop_overcurrent_in,
  // configuration
  input wire logic wd_in_stop_en_in,
  input wire logic can_wake_en_in,
  input wire logic [`WAKE_LINES-1:0] wake_line_en_in,
  input wire logic debug_mode_in,
  // regulator and pin drive
  output logic main_reg_on_out,
  output logic main_reg_lowpwr_out,
  output logic aux_regulator_on_out,
  output logic can_tx_en_out,
  output logic wd_run_out,
  output logic rstn_out,
  output logic intn_out,
  // status
  output sbc_mode_pkg::mode_t mode_out,
  output logic can_wake_flag_out,
  output logic [`WAKE_LINES-1:0] wake_line_flag_out,
  output logic interrupt_flag_reg_out
);
  import sbc_mode_pkg::*;

  localparam int unsigned NW = `WAKE_LINES;
  localparam int unsigned CW = 26;

  // ==========================================================
  // link domain: frame-done toggle, command and config held stable
  logic frame_tgl_q;
  mode_cmd_t frame_cmd_q;
  logic frame_cfg_q;
  always_ff @(posedge spi_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_tgl_q <= 1'b0;
      frame_cmd_q <= CMD_NONE;
      frame_cfg_q <= 1'b0;
    end else if (spi_frame_done_in) begin // action at frame-done strobe, before chip-select rise
      frame_tgl_q <= ~frame_tgl_q;
      frame_cmd_q <= spi_cmd_in;
      frame_cfg_q <= spi_wd_config_in;
    end
  end

  // ==========================================================
  // synchronisers for all asynchronous inputs
  localparam int unsigned NS = 11 + 2 * NW;
  logic [NS-1:0] async_raw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  assign async_raw = {frame_tgl_q, spi_csn_in, vdd_low_in, wd_timeout_in, wd_closed_trig_in,
                      can_wake_in, forced_wake_in, stop_overcurrent_in, wake_line_in,
                      wake_line_en_in, can_wake_en_in, wd_in_stop_en_in, debug_mode_in};
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= '0;
      sync1_q[NS-2] <= 1'b1; // select idles high, so no false rise after reset
      sync2_q <= '0;
      sync2_q[NS-2] <= 1'b1;
    end else begin
      sync1_q <= async_raw;
      sync2_q <= sync1_q;
    end
  end

  logic frame_tgl_s, csn_s, vdd_low_s, wd_to_s, wd_cl_s, can_wk_s, fwu_s, oc_s;
  logic [NW-1:0] line_s, line_en_s;
  logic can_en_s, wd_stop_s, debug_s;
  assign {frame_tgl_s, csn_s, vdd_low_s, wd_to_s, wd_cl_s, can_wk_s, fwu_s, oc_s,
          line_s, line_en_s, can_en_s, wd_stop_s, debug_s} = sync2_q;

  // edge detectors on synchronised copies only
  logic frame_tgl_d1_q, csn_d1_q;
  logic [NW-1:0] line_d1_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_tgl_d1_q <= 1'b0;
      csn_d1_q <= 1'b1;
      line_d1_q <= '0;
    end else begin
      frame_tgl_d1_q <= frame_tgl_s;
      csn_d1_q <= csn_s;
      line_d1_q <= line_s;
    end
  end
  logic frame_evt, csn_rise;
  logic [NW-1:0] line_chg;
  assign frame_evt = frame_tgl_s ^ frame_tgl_d1_q;
  assign csn_rise = csn_s & ~csn_d1_q;
  assign line_chg = (line_s ^ line_d1_q) & line_en_s;

  // ==========================================================
  // mode state and timers
  mode_t mode_q;
  origin_t origin_q;
  logic [CW-1:0] timer_q;
  logic [CW-1:0] spi_gap_q;
  logic [CW-1:0] int_cnt_q;
  logic int_pend_q;
  logic [CW-1:0] deglitch_q;

  // spi commands accepted only after the post-interrupt delay
  logic spi_ok;
  assign spi_ok = (spi_gap_q == '0) && !int_pend_q && (int_cnt_q == '0);
  logic cmd_evt;
  assign cmd_evt = frame_evt && spi_ok;

  // stop and sleep commands wait for the chip-select rise ending their frame
  mode_cmd_t lp_cmd_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lp_cmd_q <= CMD_NONE;
    end else if (mode_q != MODE_NORMAL && mode_q != MODE_STANDBY) begin
      lp_cmd_q <= CMD_NONE;
    end else if (cmd_evt) begin
      lp_cmd_q <= (frame_cmd_q == CMD_STOP || frame_cmd_q == CMD_SLEEP) ? frame_cmd_q : CMD_NONE;
    end else if (csn_rise) begin
      lp_cmd_q <= CMD_NONE;
    end
  end

  // wake causes in stop
  logic wake_own, wake_oc, wake_any;
  assign wake_own = (can_wk_s & can_en_s) | (|line_chg) | fwu_s;
  assign wake_oc = oc_s && (deglitch_q == '0); // over-current after deglitch
  assign wake_any = wake_own | csn_rise | wake_oc;

  // watchdog effective only outside debug variants
  logic wd_active;
  assign wd_active = !debug_s;
  logic reset_cause;
  assign reset_cause = vdd_low_s | (wd_active & (wd_to_s | wd_cl_s));

  // mode transitions
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= MODE_RESET;
      origin_q <= ORIGIN_RESET;
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 1'b1;
      case (mode_q)
        MODE_RESET: begin
          if (reset_cause) begin
            timer_q <= '0;
          end else if (timer_q >= CW'(RESET_PULSE_CYCLES - 1)) begin
            mode_q <= MODE_NORM_REQ;
            timer_q <= '0; // 350 ms timer starts
          end
        end
        MODE_NORM_REQ: begin
          if (vdd_low_s) begin
            mode_q <= MODE_RESET;
            timer_q <= '0;
          end else if (cmd_evt && frame_cfg_q && frame_cmd_q == CMD_STANDBY) begin
            mode_q <= MODE_STANDBY;
          end else if (cmd_evt && frame_cfg_q) begin
            mode_q <= MODE_NORMAL;
          end else if (timer_q >= CW'(NR_TIMEOUT_CYCLES - 1)) begin
            timer_q <= '0;
            if (origin_q == ORIGIN_SLEEP) begin
              mode_q <= MODE_SLEEP;
            end else begin
              mode_q <= MODE_RESET; // loops without limit
              origin_q <= ORIGIN_RESET;
            end
          end
        end
        MODE_NORMAL, MODE_STANDBY: begin
          if (reset_cause) begin
            mode_q <= MODE_RESET;
            origin_q <= ORIGIN_RESET;
            timer_q <= '0;
          end else if (csn_rise && lp_cmd_q == CMD_STOP) begin
            mode_q <= MODE_STOP; // only at chip-select rise
            timer_q <= '0; // timer cleared; watchdog reset in stop comes from wd_timeout_in
          end else if (csn_rise && lp_cmd_q == CMD_SLEEP) begin
            mode_q <= MODE_SLEEP; // own frame end must not wake it
          end else if (cmd_evt) begin // frame end only
            case (frame_cmd_q)
              CMD_NORMAL: mode_q <= MODE_NORMAL;
              CMD_STANDBY: mode_q <= MODE_STANDBY;
              default: mode_q <= mode_q; // stop and sleep held for select rise
            endcase
          end
        end
        MODE_STOP: begin
          if (vdd_low_s) begin
            mode_q <= MODE_RESET;
            origin_q <= ORIGIN_RESET;
            timer_q <= '0;
          end else if (wake_any) begin
            mode_q <= MODE_NORM_REQ; // direct, no reset pass
            origin_q <= ORIGIN_STOP;
            timer_q <= '0;
          end else if (wd_stop_s && wd_active && wd_to_s) begin
            mode_q <= MODE_RESET; // reset pulse then request
            origin_q <= ORIGIN_RESET;
            timer_q <= '0;
          end
        end
        MODE_SLEEP: begin
          if (wake_own || csn_rise) begin
            mode_q <= MODE_RESET; // sleep wake passes reset first
            origin_q <= ORIGIN_SLEEP;
            timer_q <= '0;
          end
        end
        default: begin
          mode_q <= MODE_RESET;
          origin_q <= ORIGIN_RESET;
        end
      endcase
    end
  end

  // sleep origin survives the reset pass into normal request
  logic stop_wake;
  assign stop_wake = (mode_q == MODE_STOP) && wake_any && !vdd_low_s;

  // ==========================================================
  // stop-entry deglitch for over-current
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      deglitch_q <= '0;
    end else if (mode_q != MODE_STOP) begin
      deglitch_q <= CW'(`STOP_DEGLITCH_CYC); // reload while outside stop
    end else if (deglitch_q != '0) begin
      deglitch_q <= deglitch_q - 1'b1;
    end
  end

  // ==========================================================
  // interrupt pulse after a stop wake into normal request, then spi gap
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_pend_q <= 1'b0;
      int_cnt_q <= '0;
      spi_gap_q <= '0;
    end else begin
      if (stop_wake) begin
        int_pend_q <= 1'b1; // pulse starts once in normal request
      end else if (int_pend_q && mode_q == MODE_NORM_REQ) begin
        int_pend_q <= 1'b0;
        int_cnt_q <= CW'(`INT_PULSE_CYC); // non-maskable
      end else if (int_cnt_q != '0) begin
        int_cnt_q <= int_cnt_q - 1'b1;
        if (int_cnt_q == CW'(1)) begin
          spi_gap_q <= CW'(FIRST_SPI_DELAY_CYCLES);
        end
      end else if (spi_gap_q != '0) begin
        spi_gap_q <= spi_gap_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // wake cause flags; cleared by a configuring frame, except line flags in stop and sleep, which keep their value; set wins
  logic can_flag_q;
  logic [NW-1:0] line_flag_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      can_flag_q <= 1'b0;
      line_flag_q <= '0;
    end else begin
      if (cmd_evt && frame_cfg_q) begin
        can_flag_q <= 1'b0;
        line_flag_q <= '0;
      end
      if (mode_q == MODE_STOP || mode_q == MODE_SLEEP) begin
        // over-current and forced wake leave flags untouched
        if (can_wk_s && can_en_s) begin
          can_flag_q <= 1'b1;
        end
        line_flag_q <= line_flag_q | line_chg;
      end
    end
  end

  // ==========================================================
  // decoded outputs from the encoded state
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_reg_on_out <= 1'b0;
      main_reg_lowpwr_out <= 1'b0;
      aux_regulator_on_out <= 1'b0;
      can_tx_en_out <= 1'b0;
      wd_run_out <= 1'b0;
      rstn_out <= 1'b0;
      intn_out <= 1'b1;
    end else begin
      main_reg_on_out <= (mode_q != MODE_SLEEP);
      main_reg_lowpwr_out <= (mode_q == MODE_STOP);
      aux_regulator_on_out <= (mode_q == MODE_NORMAL); // off in standby
      can_tx_en_out <= (mode_q == MODE_NORMAL);
      wd_run_out <= wd_active && ((mode_q == MODE_NORMAL) || (mode_q == MODE_STANDBY) ||
                    (mode_q == MODE_STOP && wd_stop_s));
      rstn_out <= !((mode_q == MODE_RESET) || (mode_q == MODE_SLEEP) || vdd_low_s);
      intn_out <= (int_cnt_q == '0); // low pulse
    end
  end

  assign mode_out = mode_q;
  assign can_wake_flag_out = can_flag_q;
  assign wake_line_flag_out = line_flag_q;
  assign interrupt_flag_reg_out = 1'b0; // stop wakes never set a maskable flag
  assign spi_accept_out = spi_ok;
endmodule : sbc_mode_wake_sequencer
`default_nettype wire

// file: tb_sbc_mode_wake_sequencer.sv
/* self-checking bench for the mode sequencer.
   assumes shortened timeout, reset and first-command counts. */
`timescale 1ns/10ps
`default_nettype none
`include "sbc_mode_consts.svh"
module tb_sbc_mode_wake_sequencer;
  import sbc_mode_pkg::*;
  localparam int unsigned NRT = 2000;
  localparam int unsigned RPC = 100;
  logic clock_in, rstn_in, spi_clk_in, spi_csn_in, spi_frame_done_in, spi_wd_config_in;
  logic vdd_low_in, wd_timeout_in, wd_closed_trig_in, can_wake_in, forced_wake_in;
  logic stop_overcurrent_in, wd_in_stop_en_in, can_wake_en_in, debug_mode_in;
  logic spi_accept_out, main_reg_on_out, main_reg_lowpwr_out, aux_regulator_on_out;
  logic can_tx_en_out, wd_run_out, rstn_out, intn_out, can_wake_flag_out;
  logic interrupt_flag_reg_out;
  logic [`WAKE_LINES-1:0] wake_line_in, wake_line_en_in, wake_line_flag_out;
  mode_cmd_t spi_cmd_in;
  mode_t mode_out;
  int n_mismatch, cmp_count, seed, idx;
  sbc_mode_wake_sequencer #(.NR_TIMEOUT_CYCLES(NRT), .RESET_PULSE_CYCLES(RPC),
    .FIRST_SPI_DELAY_CYCLES(50)) u_sbc_mode_wake_sequencer (
    .clock_in, .rstn_in, .spi_clk_in, .spi_csn_in, .spi_frame_done_in, .spi_cmd_in,
    .spi_wd_config_in, .spi_accept_out, .vdd_low_in, .wd_timeout_in, .wd_closed_trig_in,
    .can_wake_in, .wake_line_in, .forced_wake_in, .stop_overcurrent_in, .wd_in_stop_en_in,
    .can_wake_en_in, .wake_line_en_in, .debug_mode_in, .main_reg_on_out,
    .main_reg_lowpwr_out, .aux_regulator_on_out, .can_tx_en_out, .wd_run_out, .rstn_out,
    .intn_out, .mode_out, .can_wake_flag_out, .wake_line_flag_out, .interrupt_flag_reg_out);
  sbc_host_model u_sbc_host_model (.spi_clk_out(spi_clk_in), .spi_csn_out(spi_csn_in),
    .frame_done_out(spi_frame_done_in), .cmd_out(spi_cmd_in),
    .wd_config_out(spi_wd_config_in));
  // ====
  // compare helpers
  task automatic chk_mode(input string nm, input mode_t e);
    cmp_count++;
    if (mode_out !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %0d got %0d", nm, e, mode_out);
    end
  endtask : chk_mode
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val
  task automatic wait_mode(input string nm, input mode_t m, input int n);
    for (int i = 0; i < n && mode_out !== m; i++) @(posedge clock_in);
    chk_mode(nm, m);
  endtask : wait_mode
  // host waits out the quiet gap before any frame
  task automatic ready();
    for (int i = 0; i < 4000 && spi_accept_out !== 1'b1; i++) @(posedge clock_in);
  endtask : ready
  task automatic send(input mode_cmd_t c);
    ready();
    u_sbc_host_model.frame(c, 1'b1, 2);
    repeat (8) @(posedge clock_in);
  endtask : send
  task automatic enter_stop(input mode_t prev);
    ready();
    fork
      u_sbc_host_model.frame(CMD_STOP, 1'b1, 12);
      begin
        @(posedge spi_frame_done_in);
        repeat (6) @(posedge clock_in);
        chk_mode("stop_early", prev);
      end
    join
    wait_mode("stop", MODE_STOP, 10);
  endtask : enter_stop
  task automatic int_pulse();
    int n;
    n = 0;
    for (int i = 0; i < 20 && intn_out !== 1'b0; i++) @(posedge clock_in);
    while (intn_out === 1'b0 && n < 2000) begin
      @(posedge clock_in);
      n++;
    end
    chk_val("int_width", 16'(`INT_PULSE_CYC), 16'(n));
  endtask : int_pulse
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // clock and watchdog
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    {vdd_low_in, wd_timeout_in, wd_closed_trig_in, can_wake_in, forced_wake_in} = 5'h00;
    {stop_overcurrent_in, wd_in_stop_en_in, debug_mode_in} = 3'h0;
    can_wake_en_in = 1'b1;
    wake_line_en_in = '1;
    wake_line_in = '0;
    seed = 32'hb2ae;
    n_mismatch = 0;
    cmp_count = 0;
    rstn_in = 1'b0;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    wait_mode("por_nr", MODE_NORM_REQ, RPC + 20);
    repeat (2) begin
      wait_mode("nr_to_rst", MODE_RESET, NRT + 20);
      wait_mode("rst_to_nr", MODE_NORM_REQ, RPC + 20);
    end
    send(CMD_NORMAL);
    chk_mode("normal", MODE_NORMAL);
    chk_val("aux_on", 16'h1, 16'(aux_regulator_on_out));
    send(CMD_STANDBY);
    chk_val("sb_out", 16'h1, 16'({aux_regulator_on_out, can_tx_en_out, wd_run_out}));
    for (int k = 0; k < 5; k++) begin
      enter_stop(MODE_STANDBY);
      idx = $random(seed) & 3;
      @(posedge clock_in);
      chk_val("stop_lowpwr", 16'h1, 16'(main_reg_lowpwr_out));
      case (k)
        0: u_sbc_host_model.wake();
        1: can_wake_in <= 1'b1;
        2: wake_line_in[idx] <= ~wake_line_in[idx];
        3: forced_wake_in <= 1'b1;
        default: stop_overcurrent_in <= 1'b1;
      endcase
      if (k == 4) begin
        repeat (4000) @(posedge clock_in);
        chk_mode("ovc_deglitch", MODE_STOP);
      end
      wait_mode("wake", MODE_NORM_REQ, 2000);
      int_pulse();
      chk_val("flags", (k == 1) ? 16'h10 : (k == 2) ? 16'(1 << idx) : 16'h0,
        16'({can_wake_flag_out, wake_line_flag_out}));
      can_wake_in <= 1'b0;
      forced_wake_in <= 1'b0;
      stop_overcurrent_in <= 1'b0;
      send(CMD_STANDBY);
      chk_mode("back", MODE_STANDBY);
    end
    send(CMD_SLEEP);
    can_wake_in <= 1'b1;
    wait_mode("sleep_wake", MODE_RESET, 20);
    can_wake_in <= 1'b0;
    wait_mode("sleep_nr", MODE_NORM_REQ, RPC + 20);
    wait_mode("nr_sleep", MODE_SLEEP, NRT + 20);
    u_sbc_host_model.wake();
    wait_mode("sleep_csn", MODE_NORM_REQ, RPC + 40);
    send(CMD_STANDBY);
    wd_in_stop_en_in <= 1'b1;
    enter_stop(MODE_STANDBY);
    wd_timeout_in <= 1'b1;
    for (int i = 0; i < 20 && rstn_out !== 1'b0; i++) @(posedge clock_in);
    chk_val("wd_stop_rst", 16'h0, 16'(rstn_out));
    wd_timeout_in <= 1'b0;
    wait_mode("wd_stop_nr", MODE_NORM_REQ, RPC + 40);
    send(CMD_NORMAL);
    debug_mode_in <= 1'b1;
    wd_timeout_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    chk_mode("dbg_hold", MODE_NORMAL);
    chk_val("dbg_wd", 16'h0, 16'(wd_run_out));
    vdd_low_in <= 1'b1;
    wait_mode("vdd_rst", MODE_RESET, 20);
    stop_test();
  end
endmodule : tb_sbc_mode_wake_sequencer
`default_nettype wire
